// File: rtl/periodic_tick_timer.sv
// Periodic tick timer with its three registers on an AXI4-Lite slave.
// Assumes one 250 MHz clock, an asynchronous reference clock pin,
// and a processor that takes the one-cycle tick exception pulse.
`timescale 1ns/1ns

//
// Contract
// R1: The timer is a 24-bit down counter that wraps at zero, and a software write clears it.
// R2: While enabled it counts down to zero, loads the reload value on the next tick, then goes on.
// R3: The reached-zero flag at bit 16 of the control register sets on each count from 1 to 0.
// R4: The flag clears when software reads the control register or writes the current value.
// R5: A reload value of zero keeps the counter at zero after the wrap.
// R6: Software should clear the current value before enabling so counting starts from reload.
// R7: Clock source bit 2 picks the reference clock when 0 and the core clock when 1.
// R8: With bit 1 set a count to zero pends the tick exception, otherwise only the flag shows it.
// R9: Clearing the current value by a write never pends the tick exception.
// R10: Enable bit 0 stops the counter when 0 and runs it repeatedly when 1.
// R11: The reload register holds 24 bits in [23:0] and reads zero in [31:24].
// R12: Reading the current value returns the live count; any write clears it to zero.
// R13: While disabled the counter holds and raises neither the flag nor the exception.
module periodic_tick_timer #(
    parameter int unsigned COUNT_W = tick_timer_pkg::TICK_COUNT_W
) (
    // Clock and reset
    input  wire logic                                  clock,
    input  wire logic                                  resetn,
    // AXI4-Lite write address
    input  wire logic [tick_timer_pkg::AXI_ADDR_W-1:0] awaddr,
    input  wire logic                                  awvalid,
    output logic                                       awready,
    // AXI4-Lite write data
    input  wire logic [tick_timer_pkg::AXI_DATA_W-1:0] wdata,
    input  wire logic [tick_timer_pkg::AXI_STRB_W-1:0] wstrb,
    input  wire logic                                  wvalid,
    output logic                                       wready,
    // AXI4-Lite write response
    output logic [1:0]                                 bresp,
    output logic                                       bvalid,
    input  wire logic                                  bready,
    // AXI4-Lite read address
    input  wire logic [tick_timer_pkg::AXI_ADDR_W-1:0] araddr,
    input  wire logic                                  arvalid,
    output logic                                       arready,
    // AXI4-Lite read data
    output logic [tick_timer_pkg::AXI_DATA_W-1:0]      rdata,
    output logic [1:0]                                 rresp,
    output logic                                       rvalid,
    input  wire logic                                  rready,
    // Reference clock pin and exception request
    input  wire logic                                  refClockPin,
    output logic                                       tickPending
);
    import tick_timer_pkg::*;

    localparam int unsigned WORD_LSB = 2;
    localparam int unsigned RELOAD_BYTES = COUNT_W / 8;

    // Write channel registers
    logic                  awready_reg;
    logic                  wready_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic [AXI_ADDR_W-1:0] awAddr_reg;
    logic [AXI_DATA_W-1:0] wData_reg;
    logic [AXI_STRB_W-1:0] wStrb_reg;

    // Read channel registers
    logic                  arready_reg;
    logic                  rvalid_reg;
    logic [1:0]            rresp_reg;
    logic [AXI_DATA_W-1:0] rdata_reg;

    // Timer state
    tick_ctrl_t            ctrl_reg;
    tick_ctrl_t            ctrl_next;
    logic [COUNT_W-1:0]    reload_reg;
    logic [COUNT_W-1:0]    reload_next;
    logic                  reachedZeroFlag_reg;
    logic                  reachedZeroFlag_next;
    logic                  tickPending_reg;

    // Counter side
    logic [COUNT_W-1:0]    count;
    logic                  zeroEvent;
    logic                  refTick;
    logic                  stepTick;
    logic                  countStep;

    // Reference pin is asynchronous, so it is synchronised first
    ref_tick_sync refSync (
        .clock       (clock),
        .resetn      (resetn),
        .refClockPin (refClockPin),
        .refTick     (refTick)
    );

    // Decode of the captured write
    wire awTake   = awvalid & awready_reg;
    wire wTake    = wvalid & wready_reg;
    wire doWrite  = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire bDone    = bvalid_reg & bready;

    wire [AXI_ADDR_W-1:WORD_LSB] wrWord = awAddr_reg[AXI_ADDR_W-1:WORD_LSB];
    wire wrSelCtrl   = (wrWord == TICK_CONTROL_STATUS_OFFS[AXI_ADDR_W-1:WORD_LSB]);
    wire wrSelReload = (wrWord == TICK_RELOAD_VALUE_OFFS[AXI_ADDR_W-1:WORD_LSB]);
    wire wrSelCount  = (wrWord == TICK_CURRENT_VALUE_OFFS[AXI_ADDR_W-1:WORD_LSB]);
    wire wrMapped    = wrSelCtrl | wrSelReload | wrSelCount;

    wire ctrlWrite   = doWrite & wrSelCtrl & wStrb_reg[CTRL_STRB_LANE];
    wire reloadWrite = doWrite & wrSelReload;
    // Strobes ignored here: any write to the count clears it
    wire countClear  = doWrite & wrSelCount;                  // R12

    // Decode of the read address at the moment it is taken
    wire arTake = arvalid & arready_reg;
    wire rDone  = rvalid_reg & rready;

    wire [AXI_ADDR_W-1:WORD_LSB] rdWord = araddr[AXI_ADDR_W-1:WORD_LSB];
    wire rdSelCtrl   = (rdWord == TICK_CONTROL_STATUS_OFFS[AXI_ADDR_W-1:WORD_LSB]);
    wire rdSelReload = (rdWord == TICK_RELOAD_VALUE_OFFS[AXI_ADDR_W-1:WORD_LSB]);
    wire rdSelCount  = (rdWord == TICK_CURRENT_VALUE_OFFS[AXI_ADDR_W-1:WORD_LSB]);
    wire rdMapped    = rdSelCtrl | rdSelReload | rdSelCount;
    wire ctrlRead    = arTake & rdSelCtrl;

    // Read words; reserved bits read as zero
    wire [AXI_DATA_W-1:0] ctrlWord =
        AXI_DATA_W'(ctrl_reg) |
        (AXI_DATA_W'(reachedZeroFlag_reg) << REACHED_ZERO_FLAG_BIT);  // R3
    wire [AXI_DATA_W-1:0] reloadWord = AXI_DATA_W'(reload_reg);      // R11
    wire [AXI_DATA_W-1:0] countWord  = AXI_DATA_W'(count);           // R12
    wire [AXI_DATA_W-1:0] readWord =
        rdSelCtrl   ? ctrlWord :
        rdSelReload ? reloadWord :
        rdSelCount  ? countWord : '0;

    // Clock source picks core every cycle or reference edges
    assign stepTick  = ctrl_reg.clockSourceSelect | refTick;         // R7
    // Disabled counter never steps, so no flag and no exception
    assign countStep = ctrl_reg.counterEnable & stepTick;            // R10 R13

    tick_down_counter #(
        .COUNT_W (COUNT_W)
    ) downCounter (
        .clock       (clock),
        .resetn      (resetn),
        .countStep   (countStep),
        .clearNow    (countClear),
        .reloadValue (reload_reg),
        .count       (count),
        .zeroEvent   (zeroEvent)
    );

    // Control fields take the low byte lane only
    assign ctrl_next = ctrlWrite ?
        tick_ctrl_t'(wData_reg[CTRL_FIELD_W-1:0]) : ctrl_reg;

    // Reload bytes follow their strobes; upper byte is reserved
    generate
        for (genvar b = 0; b < RELOAD_BYTES; b++) begin : gReloadByte
            assign reload_next[b*8 +: 8] = (reloadWrite && wStrb_reg[b]) ?
                wData_reg[b*8 +: 8] : reload_reg[b*8 +: 8];              // R11
        end
    endgenerate

    // A new zero wins over a read clear in the same cycle; a write clear blocks the zero
    assign reachedZeroFlag_next = zeroEvent |                          // R3
        (reachedZeroFlag_reg & ~ctrlRead & ~countClear);              // R4

    // Write address and data, captured in either order
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            awready_reg <= 1'b1;
            awAddr_reg  <= '0;
        end else if (awTake) begin
            awready_reg <= 1'b0;
            awAddr_reg  <= awaddr;
        end else if (bDone) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wready_reg <= 1'b1;
            wData_reg  <= '0;
            wStrb_reg  <= '0;
        end else if (wTake) begin
            wready_reg <= 1'b0;
            wData_reg  <= wdata;
            wStrb_reg  <= wstrb;
        end else if (bDone) begin
            wready_reg <= 1'b1;
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bDone) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read sampled at address acceptance, so the flag is seen before clearing
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= '0;
        end else if (arTake) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            rdata_reg   <= readWord;
        end else if (rDone) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // Timer registers; reload has no defined reset, zero is chosen
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg            <= CTRL_RESET;
            reload_reg          <= COUNT_W'(RELOAD_RESET);
            reachedZeroFlag_reg <= 1'b0;
        end else begin
            ctrl_reg            <= ctrl_next;
            reload_reg          <= reload_next;
            reachedZeroFlag_reg <= reachedZeroFlag_next;
        end
    end

    // Exception pulse only for counted zeros, never for a clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tickPending_reg <= 1'b0;
        end else begin
            tickPending_reg <= zeroEvent & ctrl_reg.tickExceptionEnable;  // R8 R9
        end
    end

    // Ports straight from flops
    assign awready     = awready_reg;
    assign wready      = wready_reg;
    assign bvalid      = bvalid_reg;
    assign bresp       = bresp_reg;
    assign arready     = arready_reg;
    assign rvalid      = rvalid_reg;
    assign rresp       = rresp_reg;
    assign rdata       = rdata_reg;
    assign tickPending = tickPending_reg;

    // Checks on the timer behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    AST_DECREMENT: assert property ( // R1
        countStep && !countClear && count != '0 |=> count == $past(count) - COUNT_W'(1))
        else $error("count did not step down by one");

    AST_WRAP_RELOAD: assert property ( // R2
        countStep && !countClear && count == '0 |=> count == $past(reload_reg))
        else $error("count did not reload at zero");

    AST_FLAG_SET: assert property ( // R3
        ctrl_reg.counterEnable && stepTick && !countClear && count == COUNT_W'(1)
        |=> reachedZeroFlag_reg && count == '0)
        else $error("flag not set on count from one to zero");

    AST_FLAG_READ_CLEAR: assert property ( // R4
        ctrlRead && !zeroEvent |=> !reachedZeroFlag_reg
                                   && rdata_reg[REACHED_ZERO_FLAG_BIT] == $past(reachedZeroFlag_reg))
        else $error("flag survived a control read");

    AST_ZERO_RELOAD_STAYS: assert property ( // R5
        reload_reg == '0 && count == '0 && !ctrlWrite && !reloadWrite
        |=> count == '0 && !zeroEvent)
        else $error("zero reload did not hold the count at zero");

    AST_REF_SOURCE: assert property ( // R7
        !ctrl_reg.clockSourceSelect && !refTick && !countClear |=> $stable(count))
        else $error("count moved without a reference edge");

    AST_PEND_GATED: assert property ( // R8
        tickPending_reg |-> $past(ctrl_reg.tickExceptionEnable) && $past(zeroEvent))
        else $error("exception pended without enable or zero");

    AST_CLEAR_NO_PEND: assert property ( // R9
        countClear |=> count == '0 && !tickPending_reg ##1 !tickPending_reg)
        else $error("write clear pended the exception");

    AST_RELOAD_RESERVED: assert property ( // R11
        arTake && rdSelReload |=> rdata_reg[AXI_DATA_W-1:COUNT_W] == '0
                                  && rdata_reg[COUNT_W-1:0] == $past(reload_reg))
        else $error("reload read back wrong");

    AST_CLEAR_WRITE: assert property ( // R12
        countClear |=> count == '0 && !reachedZeroFlag_reg)
        else $error("current value write did not clear");

    AST_HOLD_DISABLED: assert property ( // R13
        !ctrl_reg.counterEnable && !countClear |=> $stable(count) && !tickPending_reg)
        else $error("disabled counter moved or pended");

    // Source, pulse, repeat reload, sticky flag and read-back checks
    AST_CORE_SOURCE: assert property ( // R7
        ctrl_reg.counterEnable && ctrl_reg.clockSourceSelect && !countClear && count != '0
        |=> count == $past(count) - COUNT_W'(1))
        else $error("core clock source did not step every cycle");

    AST_PEND_ON_ZERO: assert property ( // R8
        ctrl_reg.counterEnable && stepTick && !countClear && count == COUNT_W'(1)
        && ctrl_reg.tickExceptionEnable |=> tickPending_reg ##1 !tickPending_reg)
        else $error("enabled zero did not pend one exception pulse");

    AST_MULTI_SHOT: assert property ( // R10
        ctrl_reg.counterEnable && stepTick && !countClear && count == '0 && reload_reg != '0
        |=> count != '0)
        else $error("counter stopped at zero instead of reloading");

    AST_FLAG_HOLDS: assert property ( // R3
        reachedZeroFlag_reg && !ctrlRead && !countClear |=> reachedZeroFlag_reg)
        else $error("flag dropped without a read or clear");

    AST_FLAG_RISE: assert property ( // R3
        $rose(reachedZeroFlag_reg) |-> $past(zeroEvent))
        else $error("flag set without a counted zero");

    AST_COUNT_READ: assert property ( // R12
        arTake && rdSelCount |=> rdata_reg == AXI_DATA_W'($past(count)))
        else $error("current value read back wrong");

endmodule

// File: rtl/ref_tick_sync.sv
// Reference clock pin synchroniser and rising edge detector.
// Assumes the reference runs well below half the core clock rate.
`timescale 1ns/1ns
module ref_tick_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Pin side
    input  wire logic refClockPin,
    // Core side
    output wire logic refTick
);
    logic syncFirst_reg;
    logic syncSecond_reg;
    logic syncPrev_reg;

    // Two flops into the core domain, third flop only for the edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            syncFirst_reg  <= 1'b0;
            syncSecond_reg <= 1'b0;
            syncPrev_reg   <= 1'b0;
        end else begin
            syncFirst_reg  <= refClockPin;
            syncSecond_reg <= syncFirst_reg;
            syncPrev_reg   <= syncSecond_reg;
        end
    end

    // One-cycle enable per rising reference edge
    assign refTick = syncSecond_reg & ~syncPrev_reg;
endmodule

// File: rtl/tick_down_counter.sv
// Decrementing wrap-on-zero counter with a software clear.
// Assumes countStep is a one-cycle enable already gated by the enable bit.
`timescale 1ns/1ns
module tick_down_counter #(
    parameter int unsigned COUNT_W = 24
) (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               resetn,
    // Control
    input  wire logic               countStep,
    input  wire logic               clearNow,
    input  wire logic [COUNT_W-1:0] reloadValue,
    // State
    output wire logic [COUNT_W-1:0] count,
    output wire logic               zeroEvent
);
    import tick_timer_pkg::*;

    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;

    wire atZero = (count_reg == '0);
    wire atOne  = (count_reg == COUNT_W'(1));

    // Clear beats stepping; zero reloads, else step down
    assign count_next = clearNow ? '0 :                       // R1 R12
                        !countStep ? count_reg :              // R13
                        atZero ? reloadValue :                // R2 R5 R10 R11
                        count_reg - COUNT_W'(1);              // R1 R2

    // Event only for a counted 1 to 0 step, never for a clear
    assign zeroEvent = countStep & ~clearNow & atOne;         // R3 R9

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= COUNT_W'(COUNT_RESET);
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule

// File: shared/tick_timer_pkg.sv
// Constants and carrier types for the periodic tick timer.
// Assumes a 32-bit AXI4-Lite register port and a single 250 MHz clock.
package tick_timer_pkg;

    // Bus shape
    localparam int unsigned AXI_ADDR_W = 12;
    localparam int unsigned AXI_DATA_W = 32;
    localparam int unsigned AXI_STRB_W = AXI_DATA_W / 8;

    // Counter width and reset values
    localparam int unsigned TICK_COUNT_W = 24;
    localparam logic [TICK_COUNT_W-1:0] COUNT_RESET  = 24'h000000;
    localparam logic [TICK_COUNT_W-1:0] RELOAD_RESET = 24'h000000;

    // Register byte offsets
    localparam logic [AXI_ADDR_W-1:0] TICK_CONTROL_STATUS_OFFS = 12'h010;
    localparam logic [AXI_ADDR_W-1:0] TICK_RELOAD_VALUE_OFFS   = 12'h014;
    localparam logic [AXI_ADDR_W-1:0] TICK_CURRENT_VALUE_OFFS  = 12'h018;

    // Field positions in tick_control_status
    localparam int unsigned ENABLE_BIT            = 0;
    localparam int unsigned TICK_EXC_ENABLE_BIT   = 1;
    localparam int unsigned CLOCK_SOURCE_BIT      = 2;
    localparam int unsigned REACHED_ZERO_FLAG_BIT = 16;
    localparam int unsigned CTRL_FIELD_W          = 3;

    // Byte lane that holds the control fields
    localparam int unsigned CTRL_STRB_LANE = 0;

    // Answers on the response channels
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Software-written control fields, packed at their bit positions
    typedef struct packed {
        logic clockSourceSelect;   // 1 core clock, 0 reference clock
        logic tickExceptionEnable;
        logic counterEnable;
    } tick_ctrl_t;

    localparam tick_ctrl_t CTRL_RESET = 3'h0;

endpackage

// File: tb/tb_top.sv
// Self-checking bench for the periodic tick timer, driving its AXI4-Lite port.
// Assumes a single 250 MHz clock. The reference pin is stepped by hand, so counts are exact.
`timescale 1ns/1ns
module tb_top;
    import tick_timer_pkg::*;

    // Control word fields
    localparam logic [31:0] EN = 32'h1 << ENABLE_BIT;
    localparam logic [31:0] TE = 32'h1 << TICK_EXC_ENABLE_BIT;
    localparam logic [31:0] CS = 32'h1 << CLOCK_SOURCE_BIT;
    localparam logic [31:0] FL = 32'h1 << REACHED_ZERO_FLAG_BIT;
    localparam logic [AXI_ADDR_W-1:0] CTRL = TICK_CONTROL_STATUS_OFFS;
    localparam logic [AXI_ADDR_W-1:0] RLD  = TICK_RELOAD_VALUE_OFFS;
    localparam logic [AXI_ADDR_W-1:0] CUR  = TICK_CURRENT_VALUE_OFFS;
    localparam logic [AXI_ADDR_W-1:0] HOLE = 12'h01c;

    logic                  clock;
    logic                  resetn;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  awvalid;
    logic                  awready;
    logic [AXI_DATA_W-1:0] wdata;
    logic [AXI_STRB_W-1:0] wstrb;
    logic                  wvalid;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  bready;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  arvalid;
    logic                  arready;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
    logic                  rready;
    logic                  refClockPin;
    logic                  tickPending;
    int                    errors;
    int                    samples_checked;
    int                    pendCount;
    logic [31:0]           seed;
    logic [31:0]           rnd;
    logic [33:0]           rq[$];
    logic [33:0]           bq[$];

    periodic_tick_timer DUT (
        .clock(clock), .resetn(resetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .refClockPin(refClockPin), .tickPending(tickPending)
    );

    // Clock, 4 ns period
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Verdict, the single place the run ends
    task automatic tally_and_finish();
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timedOut();
        errors++;
        $display("Error at %0t: handshake never completed", $time);
        tally_and_finish();
    endtask

    // One write; trailing edge keeps back-to-back calls off the same time step
    task automatic writeReg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er,
                            input logic [3:0] s = 4'hf);
        int n;
        bq.push_back({32'h0, er});
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 100) timedOut();
        @(posedge clock);
    endtask

    // One read; the expected word goes to the queue before the request
    task automatic readReg(input logic [11:0] a, input logic [33:0] exp);
        int n;
        rq.push_back(exp);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 100) timedOut();
        @(posedge clock);
    endtask

    // One reference clock period; long enough for the synchroniser to pass it
    task automatic refPulse();
        refClockPin <= 1'b1;
        repeat (4) @(posedge clock);
        refClockPin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // Output watcher: answers against the oldest note, exception pulses counted
    always @(posedge clock) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (rq.size() == 0) check({rresp, rdata}, 34'h3ffffffff);
            else check({rresp, rdata}, rq.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            if (bq.size() == 0) check({32'h0, bresp}, 34'h3ffffffff);
            else check({32'h0, bresp}, bq.pop_front());
        end
        if (tickPending === 1'b1) pendCount++;
    end

    // Main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        pendCount = 0;
        seed = 32'hd89820a1;
        resetn = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, refClockPin} = '0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        readReg(CTRL, 34'h0);
        rnd = $random(seed);
        readReg(HOLE, {RESP_SLVERR, 32'h0});
        writeReg(HOLE, rnd, RESP_SLVERR);
        rnd = $random(seed) | 32'hff000000;
        writeReg(RLD, rnd, RESP_OKAY);
        readReg(RLD, {RESP_OKAY, 8'h00, rnd[23:0]});
        writeReg(RLD, 32'h3, RESP_OKAY);
        writeReg(CUR, $random(seed), RESP_OKAY);
        readReg(CUR, 34'h0);
        // Reference clock source, exception enabled
        writeReg(CTRL, EN | TE, RESP_OKAY);
        refPulse();
        readReg(CUR, 34'h3);
        refPulse();
        refPulse();
        readReg(CUR, 34'h1);
        readReg(CTRL, {2'h0, EN | TE});
        refPulse();
        readReg(CUR, 34'h0);
        readReg(CTRL, {2'h0, FL | EN | TE});
        readReg(CTRL, {2'h0, EN | TE});
        check(34'(pendCount), 34'h1);
        refPulse();
        readReg(CUR, 34'h3);
        // Disabled: count, flag and exception frozen
        writeReg(CTRL, TE, RESP_OKAY);
        repeat (4) refPulse();
        readReg(CUR, 34'h3);
        readReg(CTRL, {2'h0, TE});
        check(34'(pendCount), 34'h1);
        // Clearing write at a count of one: flag goes, nothing pended
        writeReg(CTRL, EN | TE, RESP_OKAY);
        repeat (3) refPulse();
        check(34'(pendCount), 34'h2);
        repeat (3) refPulse();
        writeReg(CUR, $random(seed), RESP_OKAY);
        readReg(CTRL, {2'h0, EN | TE});
        readReg(CUR, 34'h0);
        check(34'(pendCount), 34'h2);
        // Exception disabled: only the flag records the zero
        writeReg(RLD, 32'h1, RESP_OKAY);
        writeReg(CTRL, EN, RESP_OKAY);
        refPulse();
        refPulse();
        readReg(CTRL, {2'h0, FL | EN});
        check(34'(pendCount), 34'h2);
        // Zero reload parks the counter at zero
        writeReg(RLD, 32'h0, RESP_OKAY);
        repeat (3) refPulse();
        readReg(CUR, 34'h0);
        readReg(CTRL, {2'h0, EN});
        // Partial strobes: control needs lane 0, reload takes only its lanes
        writeReg(CTRL, CS | TE, RESP_OKAY, 4'he);
        readReg(CTRL, {2'h0, EN});
        writeReg(RLD, 32'h00aabbcc, RESP_OKAY, 4'h2);
        readReg(RLD, {RESP_OKAY, 32'h0000bb00});
        // Core clock source wraps many times with the pin idle
        writeReg(RLD, 32'h7, RESP_OKAY);
        writeReg(CTRL, CS | EN, RESP_OKAY);
        repeat (40) @(posedge clock);
        readReg(CTRL, {2'h0, FL | CS | EN});
        check(34'(pendCount), 34'h2);
        repeat (4) @(posedge clock);
        tally_and_finish();
    end
endmodule
